// ---- laa_annunciator.sv ----
`timescale 1ns/1ps
`include "laa_defs.svh"
module laa_annunciator
  import laa_pkg::*;
#(
  parameter int NUM_CH     = `LAA_NUM_CH,
  parameter int DEB_CYCLES = `LAA_DEB_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [NUM_CH-1:0] sensor_closed,
  input  wire logic [NUM_CH-1:0] polarity_inverse,
  input  wire logic [NUM_CH-1:0] water_sense,
  input  wire logic [NUM_CH-1:0] fuel_sense,
  input  wire logic              btn_mute,
  input  wire logic              btn_test,
  input  wire logic              btn_water,
  input  wire logic              btn_fuel,
  output logic                   normal_lamp,
  output logic      [NUM_CH-1:0] warn_lamp,
  output logic                   bell,
  output logic                   master_contact,
  output logic      [NUM_CH-1:0] aux_contact,
  output logic                   armed
);

  // ---------------------------------------------------------------
  // Local sizes
  // ---------------------------------------------------------------
  localparam int RAW_W     = 4 * NUM_CH + 4;
  localparam int ARM_CYC   = DEB_CYCLES + `LAA_ARM_EXTRA;
  localparam int ARM_W     = $clog2(ARM_CYC + 1);
  localparam logic [ARM_W-1:0] ARM_END = ARM_W'(ARM_CYC);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_sync1_r;
  logic rst_sync2_r;
  logic rst_n_int;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end

  assign rst_n_int = rst_sync2_r;

  // ---------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------
  logic [RAW_W-1:0]  raw_in;
  logic [RAW_W-1:0]  clean_in;
  logic [NUM_CH-1:0] sens_db;
  logic [NUM_CH-1:0] inv_db;
  logic [NUM_CH-1:0] water_db;
  logic [NUM_CH-1:0] fuel_db;
  logic              mute_db;
  logic              test_db;
  logic              water_btn_db;
  logic              fuel_btn_db;
  logic              armed_r;

  assign raw_in = {btn_fuel, btn_water, btn_test, btn_mute,
                   fuel_sense, water_sense, polarity_inverse, sensor_closed};

  laa_debounce #(
    .WIDTH      (RAW_W),
    .DEB_CYCLES (DEB_CYCLES)
  ) u_debounce (
    .clk   (clk),
    .rst_n (rst_n_int),
    .raw   (raw_in),
    .clean (clean_in)
  );

  assign sens_db      = clean_in[NUM_CH-1:0];
  assign inv_db       = clean_in[2*NUM_CH-1:NUM_CH];
  assign water_db     = clean_in[3*NUM_CH-1:2*NUM_CH];
  assign fuel_db      = clean_in[4*NUM_CH-1:3*NUM_CH];
  assign mute_db      = clean_in[4*NUM_CH];
  assign test_db      = clean_in[4*NUM_CH+1] & armed_r;
  assign water_btn_db = clean_in[4*NUM_CH+2];
  assign fuel_btn_db  = clean_in[4*NUM_CH+3];

  // ---------------------------------------------------------------
  // Arming after the filters settle
  // ---------------------------------------------------------------
  logic [ARM_W-1:0] arm_cnt_r;
  logic [ARM_W-1:0] arm_cnt_nxt;
  logic             armed_nxt;

  always_comb begin
    arm_cnt_nxt = arm_cnt_r;
    armed_nxt   = armed_r;
    if (!armed_r) begin
      if (arm_cnt_r == ARM_END) begin
        armed_nxt = 1'b1;
      end else begin
        arm_cnt_nxt = arm_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      arm_cnt_r <= '0;
      armed_r   <= 1'b0;
    end else begin
      arm_cnt_r <= arm_cnt_nxt;
      armed_r   <= armed_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] fault;
  logic [NUM_CH-1:0] fault_rise;

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      laa_channel u_channel (
        .clk            (clk),
        .rst_n          (rst_n_int),
        .armed          (armed_r),
        .contact_closed (sens_db[c]),
        .inverse        (inv_db[c]),
        .fault          (fault[c]),
        .fault_rise     (fault_rise[c])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Button edges
  // ---------------------------------------------------------------
  logic mute_prev_r;
  logic water_prev_r;
  logic fuel_prev_r;
  logic mute_press;
  logic water_release;
  logic fuel_release;

  always_comb begin
    mute_press    = mute_db & ~mute_prev_r;
    water_release = ~water_btn_db & water_prev_r;
    fuel_release  = ~fuel_btn_db & fuel_prev_r;
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      mute_prev_r  <= 1'b0;
      water_prev_r <= 1'b0;
      fuel_prev_r  <= 1'b0;
    end else begin
      mute_prev_r  <= mute_db;
      water_prev_r <= water_btn_db;
      fuel_prev_r  <= fuel_btn_db;
    end
  end

  // ---------------------------------------------------------------
  // Bell state
  // ---------------------------------------------------------------
  laa_bell_st_t st_r;
  laa_bell_st_t st_nxt;
  logic         any_fault;
  logic         any_rise;
  logic         water_leak;
  logic         fuel_leak;
  logic         recheck;

  always_comb begin
    any_fault  = |fault;
    any_rise   = |fault_rise;
    water_leak = |(fault & water_db);
    fuel_leak  = |(fault & fuel_db);
    recheck    = (water_release & water_leak)
               | (fuel_release & fuel_leak);
    st_nxt     = st_r;
    case (st_r)
      LAA_ST_QUIET: begin
        if (any_rise) begin
          st_nxt = LAA_ST_RING;
        end
      end
      LAA_ST_RING: begin
        if (any_rise) begin
          st_nxt = LAA_ST_RING;
        end else if (!any_fault) begin
          st_nxt = LAA_ST_QUIET;
        end else if (mute_press) begin
          st_nxt = LAA_ST_SILENT;
        end
      end
      LAA_ST_SILENT: begin
        if (any_rise) begin
          st_nxt = LAA_ST_RING;
        end else if (!any_fault) begin
          st_nxt = LAA_ST_QUIET;
        end else if (recheck) begin
          st_nxt = LAA_ST_RING;
        end
      end
      default: begin
        st_nxt = LAA_ST_QUIET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_r <= LAA_ST_QUIET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Lamp test
  // ---------------------------------------------------------------
  logic test_mute_r;
  logic test_mute_nxt;

  always_comb begin
    if (test_db) begin
      test_mute_nxt = test_mute_r | mute_press;
    end else begin
      test_mute_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      test_mute_r <= 1'b0;
    end else begin
      test_mute_r <= test_mute_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic              normal_r;
  logic              normal_nxt;
  logic [NUM_CH-1:0] warn_r;
  logic [NUM_CH-1:0] warn_nxt;
  logic              bell_r;
  logic              bell_nxt;
  logic              master_r;
  logic              master_nxt;
  logic [NUM_CH-1:0] aux_r;
  logic [NUM_CH-1:0] aux_nxt;

  always_comb begin
    normal_nxt = ~any_fault & ~test_db;
    warn_nxt   = fault | {NUM_CH{test_db}};
    aux_nxt    = fault;
    if (test_db) begin
      bell_nxt = ~test_mute_nxt;
    end else begin
      bell_nxt = (st_nxt == LAA_ST_RING);
    end
    if (any_rise) begin
      master_nxt = 1'b1;
    end else if (mute_press || !any_fault) begin
      master_nxt = 1'b0;
    end else begin
      master_nxt = master_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      normal_r <= `LAA_NORMAL_RST;
      warn_r   <= NUM_CH'(`LAA_LAMP_RST);
      bell_r   <= `LAA_BELL_RST;
      master_r <= `LAA_MASTER_RST;
      aux_r    <= NUM_CH'(`LAA_AUX_RST);
    end else begin
      normal_r <= normal_nxt;
      warn_r   <= warn_nxt;
      bell_r   <= bell_nxt;
      master_r <= master_nxt;
      aux_r    <= aux_nxt;
    end
  end

  assign normal_lamp    = normal_r;
  assign warn_lamp      = warn_r;
  assign bell           = bell_r;
  assign master_contact = master_r;
  assign aux_contact    = aux_r;
  assign armed          = armed_r;

endmodule // laa_annunciator

// ---- laa_defs.svh ----
`ifndef LAA_DEFS_SVH
`define LAA_DEFS_SVH
// Function
// - Keep the normal lamp lit while powered and no channel is in fault.
// - Put the normal lamp out as soon as any channel is in fault.
// - A channel fault lights that channel's warning lamp and starts the bell.
// - A mute press stops the bell and leaves the warning lamps as they are.
// - A warning lamp stays lit after muting until its own fault has cleared.
// - Every new fault on another channel lights its lamp and rings the bell again.
// - Holding lamp test puts out the normal lamp, lights all warning lamps, rings the bell.
// - Releasing lamp test returns lamps and bell to what the real faults call for.
// - A mute press while lamp test is held stops the bell.
// - The master fault contact pulls in when any of the four channels faults.
// - The master fault contact drops out when mute is pressed.
// - Each auxiliary contact follows its channel fault and ignores muting.
// - Inverse polarity: open contact is healthy, closed contact is a fault.
// - Direct polarity: open contact is a fault, closed contact is healthy.
// - When muted, releasing the water check button re-rings the bell on a water leak.
// - When muted, releasing the fuel check button re-rings the bell on a fuel leak.

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define LAA_NUM_CH       4

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LAA_CLK_KHZ      125000
`define LAA_DEB_TIME_US  10000
`define LAA_DEB_CYCLES   ((`LAA_DEB_TIME_US * `LAA_CLK_KHZ) / 1000)
`define LAA_ARM_EXTRA    3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LAA_NORMAL_RST   1'b1
`define LAA_BELL_RST     1'b0
`define LAA_MASTER_RST   1'b0
`define LAA_LAMP_RST     4'h0
`define LAA_AUX_RST      4'h0

`endif

// ---- laa_pkg.sv ----
package laa_pkg;

  // ---------------------------------------------------------------
  // Bell state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LAA_ST_QUIET  = 2'b00,
    LAA_ST_RING   = 2'b01,
    LAA_ST_SILENT = 2'b10
  } laa_bell_st_t;

endpackage

// ---- laa_debounce.sv ----
`timescale 1ns/1ps
module laa_debounce #(
  parameter int WIDTH      = 4,
  parameter int DEB_CYCLES = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);

  localparam int CNT_W = $clog2(DEB_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(DEB_CYCLES);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic             sync1_r;
      logic             sync2_r;
      logic             out_r;
      logic             out_nxt;
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;

      // ---------------------------------------------------------------
      // Stable-time filter
      // ---------------------------------------------------------------
      always_comb begin
        out_nxt = out_r;
        cnt_nxt = '0;
        if (sync2_r != out_r) begin
          if (cnt_r == CNT_END) begin
            out_nxt = sync2_r;
          end else begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          out_r   <= 1'b0;
          cnt_r   <= '0;
        end else begin
          sync1_r <= raw[i];
          sync2_r <= sync1_r;
          out_r   <= out_nxt;
          cnt_r   <= cnt_nxt;
        end
      end

      assign clean[i] = out_r;
    end
  endgenerate

endmodule // laa_debounce

// ---- laa_channel.sv ----
`timescale 1ns/1ps
module laa_channel (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic armed,
  input  wire logic contact_closed,
  input  wire logic inverse,
  output logic      fault,
  output logic      fault_rise
);

  logic fault_now;
  logic prev_r;
  logic prev_nxt;

  // ---------------------------------------------------------------
  // Polarity and new-fault detect
  // ---------------------------------------------------------------
  always_comb begin
    if (inverse) begin
      fault_now = armed & contact_closed;
    end else begin
      fault_now = armed & ~contact_closed;
    end
    prev_nxt = fault_now;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign fault      = fault_now;
  assign fault_rise = fault_now & ~prev_r;

endmodule // laa_channel

// ---- laa_sensor_model.sv ----
`timescale 1ns/1ps
module laa_sensor_model (
  input  wire logic       clk,
  input  wire logic [3:0] leak,
  input  wire logic [3:0] inv,
  input  wire logic [3:0] is_water,
  output logic      [3:0] sensor_closed,
  output logic      [3:0] water_sense,
  output logic      [3:0] fuel_sense
);
  logic [3:0] want;
  logic [3:0] seen = 4'h0;
  logic [3:0] mask = 4'h0;
  int         cnt  = 0;

  initial sensor_closed = 4'h0;
  // Closed on leak if inverse, open on leak if direct
  assign want = ~(leak ^ inv);
  assign water_sense = leak & is_water;
  assign fuel_sense = leak & ~is_water;

  // Contact bounces for a few cycles on each change
  always @(posedge clk) begin
    #1;
    if (want !== seen) begin
      mask = want ^ seen;
      seen = want;
      cnt = 3;
    end
    if (cnt > 0) begin
      sensor_closed = sensor_closed ^ mask;
      cnt = cnt - 1;
    end else begin
      sensor_closed = want;
    end
  end
endmodule // laa_sensor_model

// ---- laa_annunciator_sva.sv ----
`timescale 1ns/1ps
module laa_annunciator_chk #(
  parameter int NUM_CH     = 4,
  parameter int DEB_CYCLES = 4
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [NUM_CH-1:0] sensor_closed,
  input wire logic [NUM_CH-1:0] polarity_inverse,
  input wire logic [NUM_CH-1:0] water_sense,
  input wire logic [NUM_CH-1:0] fuel_sense,
  input wire logic              btn_mute,
  input wire logic              btn_test,
  input wire logic              btn_water,
  input wire logic              btn_fuel,
  input wire logic              normal_lamp,
  input wire logic [NUM_CH-1:0] warn_lamp,
  input wire logic              bell,
  input wire logic              master_contact,
  input wire logic [NUM_CH-1:0] aux_contact,
  input wire logic              armed
);
  // ---------------------------------------------------------------
  // Cycles since reset release
  // ---------------------------------------------------------------
  int cnt_r;
  int cnt_nxt;

  always_comb begin
    cnt_nxt = (cnt_r < DEB_CYCLES + 16) ? cnt_r + 1 : cnt_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 0;
    else cnt_r <= cnt_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_normal_lamp: assert property (normal_lamp == (warn_lamp == '0))
    else $error("normal lamp disagrees with warning lamps");
  a_aux_in_warn: assert property ((aux_contact & ~warn_lamp) == '0)
    else $error("aux contact set without warning lamp");
  a_new_fault_bell: assert property ((aux_contact & ~$past(aux_contact)) != '0
    |-> bell || (&warn_lamp)) else $error("new fault without bell");
  a_new_fault_master: assert property ((aux_contact & ~$past(aux_contact)) != '0
    |-> master_contact) else $error("new fault without master contact");
  a_master_needs_fault: assert property (master_contact |-> aux_contact != '0)
    else $error("master contact without fault");
  a_master_drop: assert property ($fell(master_contact)
    |-> !bell || aux_contact == '0) else $error("master dropped while bell rings");
  a_bell_cause: assert property ($rose(bell) |-> aux_contact != '0 || (&warn_lamp))
    else $error("bell rose without cause");
  a_idle_unarmed: assert property (!armed |-> normal_lamp && !bell && !master_contact
    && aux_contact == '0 && warn_lamp == '0) else $error("outputs active before arming");
  a_arm_delay: assert property ($rose(armed)
    |-> cnt_r >= DEB_CYCLES + 3 && cnt_r <= DEB_CYCLES + 12) else $error("arming time off");

  c_bell: cover property ($rose(bell));
  c_mute: cover property ($fell(master_contact) && aux_contact != '0);
  c_test: cover property ((&warn_lamp) && !bell);
endmodule // laa_annunciator_chk

bind laa_annunciator laa_annunciator_chk #(.NUM_CH(NUM_CH), .DEB_CYCLES(DEB_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .sensor_closed(sensor_closed),
  .polarity_inverse(polarity_inverse), .water_sense(water_sense),
  .fuel_sense(fuel_sense), .btn_mute(btn_mute), .btn_test(btn_test),
  .btn_water(btn_water), .btn_fuel(btn_fuel), .normal_lamp(normal_lamp),
  .warn_lamp(warn_lamp), .bell(bell), .master_contact(master_contact),
  .aux_contact(aux_contact), .armed(armed));

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  leak  = 4'h0;
  logic [3:0]  inv   = 4'h0;
  logic [3:0]  wat   = 4'h0;
  logic [3:0]  btn   = 4'h0;
  logic [31:0] r;
  logic [3:0]  sensor_closed, water_sense, fuel_sense, warn_lamp, aux_contact;
  logic        normal_lamp, bell, master_contact, armed;
  int          num_errors = 0;
  int          checks = 0;
  int          seed = 32'h6d808c48;
  int          cyc = 0;
  int          st = 0;
  bit          mst = 0;
  bit          tmute = 0;

  always #4 clk = ~clk;

  laa_sensor_model u_sens (.clk(clk), .leak(leak), .inv(inv), .is_water(wat),
    .sensor_closed(sensor_closed), .water_sense(water_sense), .fuel_sense(fuel_sense));

  laa_annunciator #(.NUM_CH(4), .DEB_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n),
    .sensor_closed(sensor_closed), .polarity_inverse(inv), .water_sense(water_sense),
    .fuel_sense(fuel_sense), .btn_mute(btn[0]), .btn_test(btn[1]), .btn_water(btn[2]),
    .btn_fuel(btn[3]), .normal_lamp(normal_lamp), .warn_lamp(warn_lamp), .bell(bell),
    .master_contact(master_contact), .aux_contact(aux_contact), .armed(armed));

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_all();
    repeat (24) @(posedge clk);
    @(negedge clk);
    chk("armed", 4'h1, {3'h0, armed});
    chk("normal_lamp", {3'h0, leak == 4'h0 && !btn[1]}, {3'h0, normal_lamp});
    chk("warn_lamp", btn[1] ? 4'hf : leak, warn_lamp);
    chk("aux_contact", leak, aux_contact);
    chk("bell", {3'h0, btn[1] ? !tmute : st == 1}, {3'h0, bell});
    chk("master_contact", {3'h0, mst}, {3'h0, master_contact});
  endtask

  // ---------------------------------------------------------------
  // Stimulus with reference model
  // ---------------------------------------------------------------
  task automatic set_leak(input logic [3:0] v);
    @(posedge clk) #1;
    if ((v & ~leak) != 4'h0) begin
      st = 1;
      mst = 1;
    end
    if (v == 4'h0) begin
      st = 0;
      mst = 0;
    end
    leak = v;
    check_all();
  endtask

  task automatic press(input int b, input logic v);
    @(posedge clk) #1;
    if (v && b == 0) begin
      mst = 0;
      if (st == 1) st = 2;
      if (btn[1]) tmute = 1;
    end
    if (v && b == 1) tmute = 0;
    if (!v && b == 2 && st == 2 && (leak & wat) != 4'h0) st = 1;
    if (!v && b == 3 && st == 2 && (leak & ~wat) != 4'h0) st = 1;
    btn[b] = v;
    check_all();
  endtask

  task automatic click(input int b);
    press(b, 1'b1);
    press(b, 1'b0);
  endtask

  initial begin
    r = $random(seed);
    inv = 4'ha ^ {4{r[0]}};
    wat = 4'h5 ^ {4{r[1]}};
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 100 && armed !== 1'b1; i++) @(posedge clk);
    check_all();
    for (int c = 0; c < 4; c++) begin
      set_leak(4'h1 << c);
      click(0);
      set_leak(4'h0);
    end
    set_leak(4'h1);
    click(0);
    set_leak(4'h3);
    $display("test channels done");
    for (int c = 0; c < 4; c++) begin
      set_leak(4'h1 << c);
      click(2);
      click(0);
      click(2);
      click(0);
      click(3);
    end
    set_leak(4'h0);
    $display("test check buttons done");
    press(1, 1'b1);
    click(0);
    press(1, 1'b0);
    set_leak(4'h4);
    press(1, 1'b1);
    press(1, 1'b0);
    $display("test lamp test done");
    @(posedge clk) #1;
    btn[0] = 1'b1;
    repeat (2) @(posedge clk);
    #1 btn[0] = 1'b0;
    check_all();
    $display("test glitch done");
    @(posedge clk) #1;
    rst_n = 1'b0;
    @(posedge clk) #1;
    rst_n = 1'b1;
    st = (leak != 4'h0) ? 1 : 0;
    mst = (leak != 4'h0);
    tmute = 0;
    check_all();
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      if (r[2]) set_leak(r[7:4]);
      else press(int'(r[5:4]), ~btn[r[5:4]]);
    end
    $display("test random done");
    summarize();
  end
endmodule // testbench
